// [design/plc_pkg.sv]
// Package for the PLL lock, reconfiguration and PHY clock gate block.
// Assumes a single system clock; all ends import this package.
package plc_pkg;
   localparam int CFG_DATA_W = 16;
   localparam int CFG_ADDR_W = 7;
   localparam int CFG_DEPTH = 128;
   localparam int REG_ADDR_W = 8;
   localparam int REG_DATA_W = 16;
   localparam int DESKEW_N = 2;
   localparam int PHY_SYNC_DIV = 8;
   localparam int CFG_ACK_LAT = 1;
   localparam int STEP_LAT = 4;
   localparam int LOCK_WIN = 16;
   localparam logic [15:0] CFG_RESET_VAL = 16'h0000;
   typedef enum logic [2:0] {
      PLC_DIV1,
      PLC_DIV2,
      PLC_DIV4,
      PLC_DIV8,
      PLC_DIV16
   } plc_div_t;
   localparam plc_div_t PHY_DIV_DEFAULT = PLC_DIV8;
   typedef enum {PLC_IDLE, PLC_BUSY} plc_step_t;
endpackage

// [design/plc_if.sv]
// Interface joining the lock and PHY clock block to its fabric partner.
// One clock domain; the testbench drives i_sys_clk and reset.
interface plc_if (
   input wire logic i_sys_clk
);
   import plc_pkg::*;
   logic [DESKEW_N-1:0] deskew_in_use;
   logic feedback_lock;
   logic [DESKEW_N-1:0] deskew_circuit_lock;
   logic lock;
   logic [CFG_DATA_W-1:0] cfg_write_bus;
   logic [CFG_DATA_W-1:0] cfg_read_bus;
   logic [CFG_ADDR_W-1:0] cfg_location;
   logic cfg_access_strobe;
   logic cfg_write_strobe;
   logic cfg_ack;
   logic phase_step_request;
   logic phase_step_direction_n;
   logic phase_step_complete;
   logic phy_clock_gate_enable;
   logic phy_fast_clock;
   logic [REG_ADDR_W-1:0] memphy_reg_location;
   logic [REG_DATA_W-1:0] memphy_reg_write_bus;
   logic [REG_DATA_W-1:0] memphy_reg_read_bus;
   logic memphy_reg_write_strobe;
   logic memphy_nibble_select;
   logic memphy_reg_valid;
   logic memphy_reg_clock;
   modport dev (
      input deskew_in_use, cfg_write_bus, cfg_location, cfg_access_strobe, cfg_write_strobe,
      input phase_step_request, phase_step_direction_n, phy_clock_gate_enable,
      input memphy_reg_location, memphy_reg_write_bus, memphy_reg_write_strobe, memphy_nibble_select,
      output feedback_lock, deskew_circuit_lock, lock, cfg_read_bus, cfg_ack, phase_step_complete,
      output phy_fast_clock, memphy_reg_read_bus, memphy_reg_valid, memphy_reg_clock
   );
   modport ctl (
      output deskew_in_use, cfg_write_bus, cfg_location, cfg_access_strobe, cfg_write_strobe,
      output phase_step_request, phase_step_direction_n, phy_clock_gate_enable,
      output memphy_reg_location, memphy_reg_write_bus, memphy_reg_write_strobe, memphy_nibble_select,
      input feedback_lock, deskew_circuit_lock, lock, cfg_read_bus, cfg_ack, phase_step_complete,
      input phy_fast_clock, memphy_reg_read_bus, memphy_reg_valid, memphy_reg_clock
   );
endinterface

// [design/plc_device.sv]
// Device end: lock combination, reconfiguration port, phase step, PHY clock gate.
// Assumes one system clock standing in for the reconfiguration, step and VCO clocks.
// Overview of operation
// (RQ1) Lock is feedback AND used deskew locks
// (RQ2) Feedback lock asserts after stable alignment
// (RQ3) Lock drops on stopped clock or jump
// (RQ4) Partner resets after lock loss
// (RQ5) Partner ignores unused deskew locks
// (RQ6) Read data returned on 16-bit bus
// (RQ7) Write data 16 bits, zero when unused
// (RQ8) Address 7 bits, zero when unused
// (RQ9) Every access strobe answered by ack
// (RQ10) Write strobe stores data at address
// (RQ11) Access strobe low when unused
// (RQ12) Port runs on reconfiguration clock
// (RQ13) Phase step request, direction, done pulse
// (RQ14) All controls active high except direction
// (RQ15) PHY clock gated by enable
// (RQ16) PHY clock starts aligned to slow clock
// (RQ17) Enable synchronised to divide-by-8 divider
// (RQ18) Alignment only for power-of-two ratios
// (RQ19) Controller-to-PHY register pass-through
// (RQ20) Reset restarts lock detection cleanly
// (RQ21) Enable accepted asynchronously
// (RQ22) PHY divider bypass/2/4/8/16, default 8; bypass here toggles at half the system clock, the same rate as /2
// (RQ23) One access outstanding until ack
module plc_device #(
   parameter plc_pkg::plc_div_t PHY_DIV = plc_pkg::PHY_DIV_DEFAULT,
   parameter int LOCK_CYCLES = plc_pkg::LOCK_WIN
) (
   input wire logic i_sys_clk,
   input wire logic i_sys_rst,
   input wire logic i_ref_present,
   input wire logic i_phase_jump,
   plc_if.dev bus
);
   import plc_pkg::*;

   logic [$clog2(LOCK_CYCLES+1)-1:0] lock_cnt_reg;
   logic fb_lock_reg;
   logic lock_reg;
   logic [DESKEW_N-1:0] dsk_lock_reg;
   logic [CFG_DATA_W-1:0] cfg_mem [CFG_DEPTH];
   logic [CFG_DATA_W-1:0] rd_reg;
   logic ack_reg;
   logic [2:0] step_cnt_reg;
   plc_step_t step_reg;
   logic step_done_reg;
   logic en_s1_reg;
   logic en_s2_reg;
   logic [2:0] div8_reg;
   logic gate_reg;
   logic [3:0] phy_div_reg;
   logic phy_clk_reg;
   logic [REG_DATA_W-1:0] rrd_reg;
   logic rvalid_reg;
   logic rclk_reg;

   function automatic logic div_tap(input plc_div_t d, input logic [3:0] c);
      unique case (d)
         PLC_DIV1: div_tap = 1'b1;
         PLC_DIV2: div_tap = c[0];
         PLC_DIV4: div_tap = c[1];
         PLC_DIV8: div_tap = c[2];
         PLC_DIV16: div_tap = c[3];
         default: div_tap = c[2];
      endcase
   endfunction

   // Unused deskew circuits never hold the combined lock low
   function automatic logic used_locked(input logic [DESKEW_N-1:0] locks, input logic [DESKEW_N-1:0] used);
      used_locked = &(locks | ~used);
   endfunction

   // Lock counts stable reference cycles; any loss restarts it
   // Count parks at the window so feedback lock holds without wrapping
   always_ff @(posedge i_sys_clk) begin
      if (i_sys_rst || !i_ref_present || i_phase_jump) begin // see (RQ3) see (RQ20)
         lock_cnt_reg <= '0;
         fb_lock_reg <= 1'b0;
      end else if (lock_cnt_reg == LOCK_CYCLES[$bits(lock_cnt_reg)-1:0]) begin
         fb_lock_reg <= 1'b1; // see (RQ2)
      end else begin
         lock_cnt_reg <= lock_cnt_reg + 1'b1;
      end
   end

   // Deskew circuits lock one cycle behind feedback; unused ones read low
   always_ff @(posedge i_sys_clk) begin
      if (i_sys_rst) begin
         dsk_lock_reg <= '0;
         lock_reg <= 1'b0;
      end else begin
         dsk_lock_reg <= bus.deskew_in_use & {DESKEW_N{fb_lock_reg}};
         lock_reg <= fb_lock_reg && used_locked(dsk_lock_reg, bus.deskew_in_use); // see (RQ1)
      end
   end

   // Reconfiguration store; each access either writes or reads, never both
   always_ff @(posedge i_sys_clk) begin
      if (bus.cfg_access_strobe && bus.cfg_write_strobe) begin
         cfg_mem[bus.cfg_location] <= bus.cfg_write_bus; // see (RQ10) see (RQ12)
      end
   end

   // Ack one cycle after each access; read data stands until the next read
   always_ff @(posedge i_sys_clk) begin
      if (i_sys_rst) begin
         ack_reg <= 1'b0;
         rd_reg <= CFG_RESET_VAL;
      end else begin
         ack_reg <= bus.cfg_access_strobe; // see (RQ9)
         if (bus.cfg_access_strobe && !bus.cfg_write_strobe) begin
            rd_reg <= cfg_mem[bus.cfg_location]; // see (RQ6)
         end
      end
   end

   // Phase step: fixed latency then a one-cycle done; requests while busy ignored
   // Direction is not modelled: both ways take the same latency
   always_ff @(posedge i_sys_clk) begin
      if (i_sys_rst) begin
         step_reg <= PLC_IDLE;
         step_cnt_reg <= '0;
         step_done_reg <= 1'b0;
      end else begin
         step_done_reg <= 1'b0;
         unique case (step_reg)
            PLC_IDLE: begin
               if (bus.phase_step_request) begin // see (RQ13)
                  step_reg <= PLC_BUSY;
                  step_cnt_reg <= 3'(STEP_LAT - 1);
               end
            end
            PLC_BUSY: begin
               if (step_cnt_reg == 3'h0) begin
                  step_reg <= PLC_IDLE;
                  step_done_reg <= 1'b1;
               end else begin
                  step_cnt_reg <= step_cnt_reg - 1'b1;
               end
            end
         endcase
      end
   end

   // Enable is asynchronous: two flops before use
   always_ff @(posedge i_sys_clk) begin
      if (i_sys_rst) begin
         en_s1_reg <= 1'b0;
         en_s2_reg <= 1'b0;
      end else begin
         en_s1_reg <= bus.phy_clock_gate_enable; // see (RQ21)
         en_s2_reg <= en_s1_reg;
      end
   end

   // Gate changes only at divide-by-8 wrap so first edge lands on slow clock edge
   // Costs up to eight cycles of start latency, traded for a clean first edge
   always_ff @(posedge i_sys_clk) begin
      if (i_sys_rst) begin
         div8_reg <= '0;
         gate_reg <= 1'b0;
      end else begin
         div8_reg <= div8_reg + 1'b1;
         if (div8_reg == 3'(PHY_SYNC_DIV - 1)) begin
            gate_reg <= en_s2_reg; // see (RQ17) see (RQ16)
         end
      end
   end

   // PHY clock divider restarts with the gate; ratios are powers of two only
   // Bypass cannot run faster than the system clock, so it toggles at half rate
   always_ff @(posedge i_sys_clk) begin
      if (i_sys_rst || !gate_reg) begin
         phy_div_reg <= '0;
         phy_clk_reg <= 1'b0;
      end else begin
         phy_div_reg <= phy_div_reg + 1'b1; // see (RQ22) see (RQ18)
         phy_clk_reg <= (PHY_DIV == PLC_DIV1) ? ~phy_clk_reg : div_tap(PHY_DIV, phy_div_reg); // see (RQ15)
      end
   end

   // Register pass-through from controller to PHY
   // Interface clock is the system clock halved; data and valid lag one cycle
   always_ff @(posedge i_sys_clk) begin
      if (i_sys_rst) begin
         rrd_reg <= '0;
         rvalid_reg <= 1'b0;
         rclk_reg <= 1'b0;
      end else begin
         rclk_reg <= ~rclk_reg;
         rvalid_reg <= bus.memphy_reg_write_strobe; // see (RQ19)
         rrd_reg <= bus.memphy_reg_write_bus;
      end
   end

   assign bus.feedback_lock = fb_lock_reg;
   assign bus.deskew_circuit_lock = dsk_lock_reg;
   assign bus.lock = lock_reg;
   assign bus.cfg_read_bus = rd_reg;
   assign bus.cfg_ack = ack_reg;
   assign bus.phase_step_complete = step_done_reg;
   assign bus.phy_fast_clock = phy_clk_reg;
   assign bus.memphy_reg_read_bus = rrd_reg;
   assign bus.memphy_reg_valid = rvalid_reg;
   assign bus.memphy_reg_clock = rclk_reg;
endmodule

// [design/plc_control.sv]
// Fabric end: drives the reconfiguration, step, gate and register requests.
// Assumes the same system clock as the device end.
module plc_control (
   input wire logic i_sys_clk,
   input wire logic i_sys_rst,
   input wire logic [plc_pkg::DESKEW_N-1:0] i_deskew_in_use,
   input wire logic i_cfg_req,
   input wire logic i_cfg_write,
   input wire logic [plc_pkg::CFG_ADDR_W-1:0] i_cfg_location,
   input wire logic [plc_pkg::CFG_DATA_W-1:0] i_cfg_data,
   input wire logic i_step_req,
   input wire logic i_step_up,
   input wire logic i_phy_enable,
   input wire logic i_reg_write,
   input wire logic [plc_pkg::REG_ADDR_W-1:0] i_reg_location,
   input wire logic [plc_pkg::REG_DATA_W-1:0] i_reg_data,
   input wire logic i_reg_nibble,
   output logic o_cfg_busy,
   output logic [plc_pkg::CFG_DATA_W-1:0] o_cfg_data,
   output logic o_cfg_done,
   output logic o_step_done,
   output logic o_lock,
   output logic o_pll_reset,
   plc_if.ctl bus
);
   import plc_pkg::*;

   logic acc_reg, we_reg, busy_reg, step_reg, dir_n_reg, en_reg, lock_seen_reg, prst_reg;
   logic [CFG_ADDR_W-1:0] addr_reg;
   logic [CFG_DATA_W-1:0] wd_reg, rdata_reg;
   logic cdone_reg, sdone_reg, lock_reg, rwe_reg, rnib_reg;
   logic [REG_ADDR_W-1:0] raddr_reg;
   logic [REG_DATA_W-1:0] rwd_reg;

   // Unused fields held at zero between accesses
   always_ff @(posedge i_sys_clk) begin
      if (i_sys_rst) begin
         acc_reg <= 1'b0;
         we_reg <= 1'b0;
         addr_reg <= '0;
         wd_reg <= '0;
         busy_reg <= 1'b0;
         cdone_reg <= 1'b0;
         rdata_reg <= '0;
      end else begin
         acc_reg <= 1'b0; // see (RQ11)
         we_reg <= 1'b0;
         addr_reg <= '0; // see (RQ8)
         wd_reg <= '0; // see (RQ7)
         cdone_reg <= 1'b0;
         if (i_cfg_req && !busy_reg) begin // see (RQ23)
            acc_reg <= 1'b1;
            we_reg <= i_cfg_write; // see (RQ10)
            addr_reg <= i_cfg_location;
            wd_reg <= i_cfg_write ? i_cfg_data : '0;
            busy_reg <= 1'b1;
         end else if (busy_reg && bus.cfg_ack) begin // see (RQ12)
            busy_reg <= 1'b0;
            cdone_reg <= 1'b1;
            rdata_reg <= bus.cfg_read_bus;
         end
      end
   end

   always_ff @(posedge i_sys_clk) begin
      if (i_sys_rst) begin
         step_reg <= 1'b0;
         dir_n_reg <= 1'b1;
         sdone_reg <= 1'b0;
         en_reg <= 1'b0;
      end else begin
         step_reg <= i_step_req; // see (RQ13)
         dir_n_reg <= ~i_step_up; // see (RQ14)
         sdone_reg <= bus.phase_step_complete;
         en_reg <= i_phy_enable;
      end
   end

   // Lock loss triggers a one-cycle PLL reset request
   always_ff @(posedge i_sys_clk) begin
      if (i_sys_rst) begin
         lock_reg <= 1'b0;
         lock_seen_reg <= 1'b0;
         prst_reg <= 1'b0;
      end else begin
         lock_reg <= bus.feedback_lock && ((bus.deskew_circuit_lock | ~i_deskew_in_use) == '1); // see (RQ5)
         lock_seen_reg <= lock_reg;
         prst_reg <= lock_seen_reg && !lock_reg; // see (RQ4)
      end
   end

   always_ff @(posedge i_sys_clk) begin
      if (i_sys_rst) begin
         rwe_reg <= 1'b0;
         rnib_reg <= 1'b0;
         raddr_reg <= '0;
         rwd_reg <= '0;
      end else begin
         rwe_reg <= i_reg_write;
         rnib_reg <= i_reg_nibble;
         raddr_reg <= i_reg_location;
         rwd_reg <= i_reg_data;
      end
   end

   assign bus.deskew_in_use = i_deskew_in_use;
   assign bus.cfg_access_strobe = acc_reg;
   assign bus.cfg_write_strobe = we_reg;
   assign bus.cfg_location = addr_reg;
   assign bus.cfg_write_bus = wd_reg;
   assign bus.phase_step_request = step_reg;
   assign bus.phase_step_direction_n = dir_n_reg;
   assign bus.phy_clock_gate_enable = en_reg;
   assign bus.memphy_reg_location = raddr_reg;
   assign bus.memphy_reg_write_bus = rwd_reg;
   assign bus.memphy_reg_write_strobe = rwe_reg;
   assign bus.memphy_nibble_select = rnib_reg;
   assign o_cfg_busy = busy_reg;
   assign o_cfg_data = rdata_reg;
   assign o_cfg_done = cdone_reg;
   assign o_step_done = sdone_reg;
   assign o_lock = lock_reg;
   assign o_pll_reset = prst_reg;
endmodule

// [testbench/plc_monitor.sv]
// Concurrent checks on the link between the device end and the fabric end.
// Assumes one clock domain and a synchronous active-high reset.
module plc_monitor (
   input wire logic i_sys_clk,
   input wire logic i_sys_rst,
   input wire logic [plc_pkg::DESKEW_N-1:0] deskew_in_use,
   input wire logic feedback_lock,
   input wire logic [plc_pkg::DESKEW_N-1:0] deskew_circuit_lock,
   input wire logic lock,
   input wire logic cfg_access_strobe,
   input wire logic cfg_ack,
   input wire logic phase_step_request,
   input wire logic phase_step_complete,
   input wire logic phy_clock_gate_enable,
   input wire logic phy_fast_clock,
   input wire logic memphy_reg_write_strobe,
   input wire logic [plc_pkg::REG_DATA_W-1:0] memphy_reg_write_bus,
   input wire logic [plc_pkg::REG_DATA_W-1:0] memphy_reg_read_bus,
   input wire logic memphy_reg_valid
);
   import plc_pkg::*;
   logic lock_cond;
   logic [5:0] off_reg;
   default clocking @(posedge i_sys_clk); endclocking
   default disable iff (i_sys_rst);
   assign lock_cond = feedback_lock && (&(deskew_circuit_lock | ~deskew_in_use));
   // Saturates so a long idle gate never wraps back to a small count
   always_ff @(posedge i_sys_clk) begin
      if (i_sys_rst || phy_clock_gate_enable) begin
         off_reg <= 6'h00;
      end else if (off_reg != 6'h3f) begin
         off_reg <= off_reg + 6'h01;
      end
   end
   sequence cfg_answer_s;
      cfg_ack ##1 !cfg_ack;
   endsequence
   sequence phy_wake_s;
      !phy_fast_clock [*3] ##[1:40] phy_fast_clock;
   endsequence
   lock_and_a: assert property (!$past(i_sys_rst) |-> lock == $past(lock_cond))
      else $error("lock differs from combined lock inputs");
   ack_answer_a: assert property (cfg_access_strobe |=> cfg_answer_s)
      else $error("access not answered by a single ack");
   ack_cause_a: assert property (cfg_ack |-> $past(cfg_access_strobe))
      else $error("ack without an access");
   step_done_a: assert property (phase_step_complete |-> ($past(phase_step_request, 4) ||
      $past(phase_step_request, 5) || $past(phase_step_request, 6)) ##1 !phase_step_complete)
      else $error("step completion without a step request");
   phy_off_a: assert property (off_reg > 6'h1f |-> !phy_fast_clock)
      else $error("phy clock runs while gated off");
   phy_start_a: assert property ($rose(phy_clock_gate_enable) && off_reg > 6'h1f |-> phy_wake_s)
      else $error("phy clock start not synchronised");
   phy_high_a: assert property ($rose(phy_fast_clock) |-> phy_fast_clock [*4] ##1 !phy_fast_clock)
      else $error("phy clock high phase wrong");
   reg_pass_a: assert property (!$past(i_sys_rst) |-> memphy_reg_valid == $past(memphy_reg_write_strobe) &&
      memphy_reg_read_bus == $past(memphy_reg_write_bus))
      else $error("register pass-through wrong");
endmodule

// [testbench/pll_lock_cfg_phy_clock_gate_tb_top.sv]
// Self-checking bench joining the device end and the fabric end.
// Assumes the package, interface and both design ends are compiled first.
module pll_lock_cfg_phy_clock_gate_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import plc_pkg::*;
`define CHK(nm, ex, got) begin comparisons++; if ((got) !== (ex)) begin fails++; \
   $display("unexpected %s expected %h seen %h", nm, ex, got); end end
   logic i_sys_clk = 1'b0;
   logic i_sys_rst = 1'b1;
   logic ref_ok = 1'b1;
   logic jump = 1'b0;
   logic [DESKEW_N-1:0] use_map = 2'b01;
   logic cfg_req = 1'b0;
   logic cfg_wr = 1'b0;
   logic [CFG_ADDR_W-1:0] cfg_loc = 7'h00;
   logic [CFG_DATA_W-1:0] cfg_dat = 16'h0000;
   logic step_req = 1'b0;
   logic step_up = 1'b0;
   logic phy_en = 1'b0;
   logic reg_wr = 1'b0;
   logic [REG_ADDR_W-1:0] reg_loc = 8'h00;
   logic [REG_DATA_W-1:0] reg_dat = 16'h0000;
   logic reg_nib = 1'b0;
   logic cfg_busy, cfg_done, step_done, lock_o, pll_rst, dev_rst, ph_q, ck;
   logic [CFG_DATA_W-1:0] cfg_out;
   logic [17:0] exp_q[$];
   logic [17:0] e;
   int fails = 0;
   int comparisons = 0;
   int cycles = 0;
   int rise = 0;
   int rst_cnt = 0;
   int seed = 32'hda59_17e3;
   // Fabric end pulses the device reset after a lock loss
   assign dev_rst = i_sys_rst | pll_rst;
   plc_if u_plc_if (.i_sys_clk(i_sys_clk));
   plc_device #(.LOCK_CYCLES(4)) u_plc_device (.i_sys_clk(i_sys_clk), .i_sys_rst(dev_rst),
      .i_ref_present(ref_ok), .i_phase_jump(jump), .bus(u_plc_if));
   plc_control u_plc_control (.i_sys_clk(i_sys_clk), .i_sys_rst(i_sys_rst), .i_deskew_in_use(use_map),
      .i_cfg_req(cfg_req), .i_cfg_write(cfg_wr), .i_cfg_location(cfg_loc), .i_cfg_data(cfg_dat),
      .i_step_req(step_req), .i_step_up(step_up), .i_phy_enable(phy_en), .i_reg_write(reg_wr),
      .i_reg_location(reg_loc), .i_reg_data(reg_dat), .i_reg_nibble(reg_nib), .o_cfg_busy(cfg_busy),
      .o_cfg_data(cfg_out), .o_cfg_done(cfg_done), .o_step_done(step_done), .o_lock(lock_o),
      .o_pll_reset(pll_rst), .bus(u_plc_if));
   plc_monitor u_plc_monitor (.i_sys_clk(i_sys_clk), .i_sys_rst(dev_rst), .deskew_in_use(u_plc_if.deskew_in_use),
      .feedback_lock(u_plc_if.feedback_lock), .deskew_circuit_lock(u_plc_if.deskew_circuit_lock),
      .lock(u_plc_if.lock), .cfg_access_strobe(u_plc_if.cfg_access_strobe), .cfg_ack(u_plc_if.cfg_ack),
      .phase_step_request(u_plc_if.phase_step_request), .phase_step_complete(u_plc_if.phase_step_complete),
      .phy_clock_gate_enable(u_plc_if.phy_clock_gate_enable), .phy_fast_clock(u_plc_if.phy_fast_clock),
      .memphy_reg_write_strobe(u_plc_if.memphy_reg_write_strobe),
      .memphy_reg_write_bus(u_plc_if.memphy_reg_write_bus),
      .memphy_reg_read_bus(u_plc_if.memphy_reg_read_bus), .memphy_reg_valid(u_plc_if.memphy_reg_valid));
   initial forever #4 i_sys_clk = ~i_sys_clk;
   task automatic finish_test;
      $display("comparisons %0d fails %0d", comparisons, fails);
      if (fails == 0 && comparisons > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   task automatic wait_cycles(input int n);
      repeat (n) @(negedge i_sys_clk);
   endtask
   task automatic cfg_op(input logic wr, input logic [CFG_ADDR_W-1:0] loc, input logic [CFG_DATA_W-1:0] dat);
      exp_q.push_back({1'b0, !wr, dat});
      cfg_wr = wr;
      cfg_loc = loc;
      cfg_dat = wr ? dat : ~dat;
      cfg_req = 1'b1;
      // Held into the busy cycle, where it must be ignored
      wait_cycles(2);
      `CHK("cfg busy", 1'b1, cfg_busy)
      cfg_req = 1'b0;
      repeat (20) if (cfg_done !== 1'b1) @(negedge i_sys_clk);
   endtask
   task automatic step_op(input logic up);
      exp_q.push_back({1'b1, 17'h0_0000});
      step_up = up;
      step_req = 1'b1;
      wait_cycles(2);
      step_req = 1'b0;
      repeat (20) if (step_done !== 1'b1) @(negedge i_sys_clk);
   endtask
   task automatic wait_lock(input logic want);
      repeat (40) if (lock_o !== want) @(negedge i_sys_clk);
      `CHK("lock", want, lock_o)
      `CHK("lock on link", want, u_plc_if.lock)
   endtask
   always @(posedge i_sys_clk) begin
      ph_q <= u_plc_if.phy_fast_clock;
      rise <= rise + int'(u_plc_if.phy_fast_clock & ~ph_q);
      cycles <= cycles + 1;
      if (cycles == 5000) begin
         fails++;
         finish_test();
      end
   end
   always @(negedge i_sys_clk) begin
      if (pll_rst === 1'b1) rst_cnt++;
      if (u_plc_if.phase_step_request === 1'b1) begin
         `CHK("direction", !step_up, u_plc_if.phase_step_direction_n)
      end
      if (cfg_done === 1'b1 || step_done === 1'b1) begin
         if (exp_q.size() == 0) begin
            fails++;
            $display("unexpected result expected none seen %b", {step_done, cfg_done});
         end else begin
            e = exp_q.pop_front();
            `CHK("result kind", e[17], step_done)
            if (e[16]) `CHK("cfg read data", e[15:0], cfg_out)
         end
      end
   end
   initial begin
      int i;
      logic [CFG_ADDR_W-1:0] locs[4];
      logic [CFG_DATA_W-1:0] dats[4];
      wait_cycles(8);
      i_sys_rst = 1'b0;
      wait_cycles(1);
      `CHK("idle config data", 23'h00_0000, {u_plc_if.cfg_write_bus, u_plc_if.cfg_location})
      `CHK("idle config strobes", 2'h0, {u_plc_if.cfg_access_strobe, u_plc_if.cfg_write_strobe})
      wait_lock(1'b1);
      wait_lock(1'b1);
      for (i = 0; i < 2; i++) begin
         // Second deskew joins at the jump, so its lock gap costs no extra PLL reset
         use_map = 2'b11;
         jump = (i == 0);
         ref_ok = (i == 0);
         wait_cycles(1);
         jump = 1'b0;
         wait_lock(1'b0);
         ref_ok = 1'b1;
         wait_lock(1'b1);
      end
      `CHK("pll resets", 2, rst_cnt)
      for (i = 0; i < 4; i++) begin
         locs[i] = (i == 0) ? 7'h00 : (i == 1) ? 7'h7f : {2'(i - 1), 5'($random(seed))};
         dats[i] = 16'($random(seed));
         cfg_op(1'b1, locs[i], dats[i]);
      end
      for (i = 0; i < 4; i++) cfg_op(1'b0, locs[i], dats[i]);
      for (i = 0; i < 2; i++) step_op(i[0]);
      `CHK("phy idle", 1'b0, u_plc_if.phy_fast_clock)
      phy_en = 1'b1;
      wait_cycles(40);
      i = rise;
      wait_cycles(64);
      `CHK("phy edges", 8, rise - i)
      phy_en = 1'b0;
      wait_cycles(40);
      i = rise;
      wait_cycles(32);
      `CHK("phy gated", 0, rise - i)
      for (i = 0; i < 4; i++) begin
         reg_wr = 1'b1;
         reg_loc = 8'($random(seed));
         reg_dat = 16'($random(seed));
         reg_nib = i[0];
         ck = u_plc_if.memphy_reg_clock;
         wait_cycles(1);
         `CHK("reg clock", !ck, u_plc_if.memphy_reg_clock)
         reg_wr = 1'b0;
         wait_cycles(1);
         `CHK("reg return", {1'b1, reg_dat}, {u_plc_if.memphy_reg_valid, u_plc_if.memphy_reg_read_bus})
      end
      wait_cycles(4);
      `CHK("pending results", 0, exp_q.size())
      finish_test();
   end
endmodule
